// >>> frc_pkg.sv
package frc_pkg;

  // ****************************************************************
  // data path geometry
  // ****************************************************************
  localparam int DATA_W = 36;
  localparam int HALF_W = 18;
  localparam int FIFO_DEPTH = 4;
  localparam int ALMOST_LEVEL = 1;

  // ****************************************************************
  // reset and wake-up counts, in port clock rising edges
  // ****************************************************************
  localparam logic [2:0] MIN_HOLD_EDGES = 3'h4;
  localparam logic [2:0] READY_EDGES = 3'h2;

  // ****************************************************************
  // bit positions in the synchronised pin vector
  // ****************************************************************
  localparam int PIN_COUNT = 10;
  localparam int PIN_RS1 = 0;
  localparam int PIN_RS2 = 1;
  localparam int PIN_SHARE = 2;
  localparam int PIN_MODE = 3;
  localparam int PIN_ORDER = 4;
  localparam int PIN_FS0 = 5;
  localparam int PIN_FS2 = 7;
  localparam int PIN_WCLK = 8;
  localparam int PIN_RCLK = 9;
  // pins idle as if every reset is asserted
  localparam logic [PIN_COUNT-1:0] PIN_RESET_VAL = 10'h000;

  // ****************************************************************
  // write side life cycle
  // ****************************************************************
  typedef enum logic [2:0] {
    FRC_HELD = 3'b001,
    FRC_WAKE = 3'b010,
    FRC_RUN = 3'b100
  } frc_state_t;

  function automatic logic [2:0] frc_sat_inc(input logic [2:0] value);
    return (value == 3'h7) ? value : value + 3'h1;
  endfunction

endpackage

// >>> frc_sync.sv
`timescale 1ns/100ps
module frc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("frc_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] stage_one;

  // stage_one feeds only the second flop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage_one <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule // frc_sync

// >>> frc_fifo.sv
`timescale 1ns/100ps
module frc_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic flush,
  input wire logic rewind,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);

  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_geometry
    $error("frc_fifo: WIDTH must be positive and DEPTH a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign level = wr_ptr - rd_ptr;
  assign in_ready = (level != DEPTH[AW:0]) && !flush;
  assign out_valid = (level != '0) && !flush;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // rewind returns to location zero of the current lap; older laps are overwritten
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_ptr <= '0;
    end else if (flush) begin
      rd_ptr <= '0;
    end else if (rewind) begin
      rd_ptr <= {wr_ptr[AW], {AW{1'b0}}};
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  a_rewind_to_first: assert property (@(posedge clock) disable iff (!rstn)
    (rewind && !flush) |=> (rd_ptr[AW-1:0] == '0))
    else $error("read pointer not at first location after rewind");

endmodule // frc_fifo

// >>> frc_top.sv
`timescale 1ns/100ps
module frc_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic master_reset_first_n,
  input wire logic master_reset_second_n,
  input wire logic partial_reset_n,
  input wire logic rewind_mode_select,
  input wire logic byte_order_timing_select,
  input wire logic offset_select_0,
  input wire logic offset_select_1,
  input wire logic offset_select_2,
  input wire logic write_port_clock,
  input wire logic read_port_clock,
  input wire logic write_valid,
  input wire logic [frc_pkg::DATA_W-1:0] write_data,
  output logic read_valid,
  input wire logic read_ready,
  output logic [frc_pkg::HALF_W-1:0] read_data,
  input wire logic mailbox_one_load,
  input wire logic mailbox_one_take,
  input wire logic mailbox_two_load,
  input wire logic mailbox_two_take,
  output logic full_or_input_ready_flag,
  output logic empty_or_output_ready_flag,
  output logic almost_empty_flag,
  output logic almost_full_flag,
  output logic mailbox_one_flag_n,
  output logic mailbox_two_flag_n,
  output logic byte_order_select,
  output logic [2:0] offset_method,
  output logic standard_timing_mode
);

  localparam int LW = $clog2(frc_pkg::FIFO_DEPTH) + 1;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [frc_pkg::PIN_COUNT-1:0] pins;
  logic [frc_pkg::PIN_COUNT-1:0] pins_s;

  assign pins = {read_port_clock, write_port_clock, offset_select_2, offset_select_1, offset_select_0,
                 byte_order_timing_select, rewind_mode_select, partial_reset_n, master_reset_second_n,
                 master_reset_first_n};

  // every pin, the resets among them, is taken through two flops first
  frc_sync #(
    .WIDTH(frc_pkg::PIN_COUNT),
    .RESET_VAL(frc_pkg::PIN_RESET_VAL)
  ) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in(pins),
    .sync_out(pins_s)
  );

  logic rs1_s;
  logic rs2_s;
  logic share_s;
  logic wclk_q;
  logic rclk_q;
  logic rs1_q;
  logic share_q;
  logic wclk_rise;
  logic rclk_rise;
  logic rs1_rise;
  logic share_fall;
  logic share_rise;

  assign rs1_s = pins_s[frc_pkg::PIN_RS1];
  assign rs2_s = pins_s[frc_pkg::PIN_RS2];
  assign share_s = pins_s[frc_pkg::PIN_SHARE];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
      rs1_q <= 1'b0;
      share_q <= 1'b0;
    end else begin
      wclk_q <= pins_s[frc_pkg::PIN_WCLK];
      rclk_q <= pins_s[frc_pkg::PIN_RCLK];
      rs1_q <= rs1_s;
      share_q <= share_s;
    end
  end

  assign wclk_rise = pins_s[frc_pkg::PIN_WCLK] && !wclk_q;
  assign rclk_rise = pins_s[frc_pkg::PIN_RCLK] && !rclk_q;
  assign rs1_rise = rs1_s && !rs1_q;
  assign share_fall = !share_s && share_q;
  assign share_rise = share_s && !share_q;

  // ****************************************************************
  // hold tracking: mode of the shared pin and edges seen while low
  // ****************************************************************
  logic master_low;
  logic share_low;
  logic rewind_mode_q;
  logic rewind_mode;
  logic full_hold;
  logic hold_ok;
  logic [2:0] edges_w;
  logic [2:0] edges_r;

  assign master_low = !rs1_s || !rs2_s;
  assign share_low = !share_s;

  // the mode is taken as the shared pin falls; it must stay put meanwhile
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rewind_mode_q <= 1'b0;
    end else if (share_fall) begin
      rewind_mode_q <= pins_s[frc_pkg::PIN_MODE];
    end
  end

  // the fall itself already obeys the new mode, so a rewind never flushes for a cycle
  assign rewind_mode = share_fall ? pins_s[frc_pkg::PIN_MODE] : rewind_mode_q;
  assign full_hold = master_low || (share_low && !rewind_mode);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      edges_w <= '0;
      edges_r <= '0;
    end else if (!(master_low || share_low)) begin
      edges_w <= '0;
      edges_r <= '0;
    end else begin
      if (wclk_rise) begin
        edges_w <= frc_pkg::frc_sat_inc(edges_w);
      end
      if (rclk_rise) begin
        edges_r <= frc_pkg::frc_sat_inc(edges_r);
      end
    end
  end

  assign hold_ok = (edges_w >= frc_pkg::MIN_HOLD_EDGES) && (edges_r >= frc_pkg::MIN_HOLD_EDGES);

  // a short rewind pulse is ignored; the read pointer is left alone
  logic do_rewind;
  assign do_rewind = share_rise && rewind_mode_q && hold_ok && !master_low;

  // ****************************************************************
  // write side life cycle
  // ****************************************************************
  frc_pkg::frc_state_t state;
  logic [2:0] ready_cnt;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= frc_pkg::FRC_HELD;
      ready_cnt <= '0;
    end else if (full_hold) begin
      state <= frc_pkg::FRC_HELD;
      ready_cnt <= '0;
    end else begin
      unique case (state)
        frc_pkg::FRC_HELD: begin
          state <= frc_pkg::FRC_WAKE;
        end
        frc_pkg::FRC_WAKE: begin
          if (wclk_rise) begin
            ready_cnt <= frc_pkg::frc_sat_inc(ready_cnt);
            if (frc_pkg::frc_sat_inc(ready_cnt) == frc_pkg::READY_EDGES) begin
              state <= frc_pkg::FRC_RUN;
            end
          end
        end
        frc_pkg::FRC_RUN: begin
          state <= frc_pkg::FRC_RUN;
        end
      endcase
    end
  end

  // ****************************************************************
  // configuration captured by the first master reset
  // ****************************************************************
  logic mode_pending;
  logic seen_w;
  logic seen_r;

  // partial reset never touches these
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      byte_order_select <= 1'b0;
      offset_method <= '0;
    end else if (rs1_rise) begin
      byte_order_select <= pins_s[frc_pkg::PIN_ORDER];
      offset_method <= pins_s[frc_pkg::PIN_FS2:frc_pkg::PIN_FS0];
    end
  end

  // timing mode is sampled once both port clocks have risen after release
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_pending <= 1'b0;
      seen_w <= 1'b0;
      seen_r <= 1'b0;
      standard_timing_mode <= 1'b1;
    end else if (!rs1_s) begin
      mode_pending <= 1'b0;
      seen_w <= 1'b0;
      seen_r <= 1'b0;
    end else if (rs1_rise) begin
      mode_pending <= 1'b1;
    end else if (mode_pending) begin
      seen_w <= seen_w || wclk_rise;
      seen_r <= seen_r || rclk_rise;
      if ((seen_w || wclk_rise) && (seen_r || rclk_rise)) begin
        standard_timing_mode <= pins_s[frc_pkg::PIN_ORDER];
        mode_pending <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // data path: buffer, then the half-word output stage
  // ****************************************************************
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [frc_pkg::DATA_W-1:0] fifo_out_data;
  logic [LW-1:0] level;
  logic write_ok;
  logic stage_load;
  logic second_half;
  logic [frc_pkg::HALF_W-1:0] spare;

  assign write_ok = (state == frc_pkg::FRC_RUN) && !full_hold;

  frc_fifo #(
    .WIDTH(frc_pkg::DATA_W),
    .DEPTH(frc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .flush(full_hold),
    .rewind(do_rewind),
    .in_valid(write_valid && write_ok),
    .in_ready(fifo_in_ready),
    .in_data(write_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(level)
  );

  // back-pressure: a word waits in the buffer until both halves have left
  assign fifo_out_ready = !read_valid && !do_rewind;
  assign stage_load = fifo_out_valid && fifo_out_ready;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      read_valid <= 1'b0;
      second_half <= 1'b0;
      read_data <= '0;
      spare <= '0;
    end else if (full_hold || do_rewind) begin
      read_valid <= 1'b0;
      second_half <= 1'b0;
    end else if (stage_load) begin
      read_valid <= 1'b1;
      second_half <= 1'b1;
      if (byte_order_select) begin
        read_data <= fifo_out_data[frc_pkg::DATA_W-1:frc_pkg::HALF_W];
        spare <= fifo_out_data[frc_pkg::HALF_W-1:0];
      end else begin
        read_data <= fifo_out_data[frc_pkg::HALF_W-1:0];
        spare <= fifo_out_data[frc_pkg::DATA_W-1:frc_pkg::HALF_W];
      end
    end else if (read_valid && read_ready) begin
      read_valid <= second_half;
      second_half <= 1'b0;
      read_data <= spare;
    end
  end

  // ****************************************************************
  // flags
  // ****************************************************************
  assign full_or_input_ready_flag = write_ok && fifo_in_ready;
  assign empty_or_output_ready_flag = read_valid;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      almost_empty_flag <= 1'b0;
      almost_full_flag <= 1'b1;
    end else if (full_hold) begin
      almost_empty_flag <= 1'b0;
      almost_full_flag <= 1'b1;
    end else begin
      almost_empty_flag <= level > LW'(frc_pkg::ALMOST_LEVEL);
      almost_full_flag <= (LW'(frc_pkg::FIFO_DEPTH) - level) > LW'(frc_pkg::ALMOST_LEVEL);
    end
  end

  // a load arriving with a take leaves the flag active
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mailbox_one_flag_n <= 1'b1;
    end else if (!rs1_s || (share_low && !rewind_mode)) begin
      mailbox_one_flag_n <= 1'b1;
    end else if (mailbox_one_load) begin
      mailbox_one_flag_n <= 1'b0;
    end else if (mailbox_one_take) begin
      mailbox_one_flag_n <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mailbox_two_flag_n <= 1'b1;
    end else if (!rs2_s || (share_low && !rewind_mode)) begin
      mailbox_two_flag_n <= 1'b1;
    end else if (mailbox_two_load) begin
      mailbox_two_flag_n <= 1'b0;
    end else if (mailbox_two_take) begin
      mailbox_two_flag_n <= 1'b1;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_released;
    (state == frc_pkg::FRC_WAKE) ##0 (wclk_rise && ready_cnt == 3'h1);
  endsequence

  a_hold_forces_flags: assert property (full_hold |=> !almost_empty_flag && almost_full_flag
    && !full_or_input_ready_flag && !empty_or_output_ready_flag)
    else $error("flags not forced during reset hold");
  a_ready_two_edges: assert property ((s_released ##0 !full_hold) |=> (state == frc_pkg::FRC_RUN))
    else $error("input ready not reached on second write edge");
  a_ready_needs_edge: assert property ($rose(state == frc_pkg::FRC_RUN) |-> $past(wclk_rise))
    else $error("input ready rose without a write clock edge");
  a_mailbox_one_high: assert property (!rs1_s |=> mailbox_one_flag_n)
    else $error("first mailbox flag not forced high");
  a_mailbox_two_high: assert property (!rs2_s |=> mailbox_two_flag_n)
    else $error("second mailbox flag not forced high");
  a_order_capture: assert property (rs1_rise |=> byte_order_select == $past(pins_s[frc_pkg::PIN_ORDER])
    && offset_method == $past(pins_s[frc_pkg::PIN_FS2:frc_pkg::PIN_FS0]))
    else $error("configuration not captured on first master reset rise");
  a_partial_keeps_cfg: assert property ((share_low && !rewind_mode_q && rs1_s && rs2_s)
    |=> $stable(byte_order_select) && $stable(offset_method) && $stable(standard_timing_mode))
    else $error("partial reset changed configuration");
  a_mode_pick: assert property (share_fall |=> rewind_mode_q == $past(pins_s[frc_pkg::PIN_MODE]))
    else $error("shared pin mode not taken at fall");
  a_short_no_rewind: assert property ((share_rise && rewind_mode_q && !hold_ok) |-> !do_rewind)
    else $error("rewind taken from a short pulse");
  a_upper_first: assert property ((stage_load && byte_order_select && !full_hold && !do_rewind)
    |=> read_data == $past(fifo_out_data[frc_pkg::DATA_W-1:frc_pkg::HALF_W]))
    else $error("upper half not delivered first");

endmodule // frc_top

// >>> frc_host.sv
`timescale 1ns/100ps
module frc_host (
  input wire logic clock,
  output logic write_port_clock,
  output logic read_port_clock,
  output logic write_valid,
  output logic [frc_pkg::DATA_W-1:0] write_data,
  input wire logic full_or_input_ready_flag,
  input wire logic read_valid,
  output logic read_ready,
  input wire logic [frc_pkg::HALF_W-1:0] read_data
);
  // ****************************************************************
  // port clocks, unequal rates so their edges drift apart
  // ****************************************************************
  initial begin
    write_port_clock = 1'b0;
    forever begin
      repeat (4) @(posedge clock);
      #1 write_port_clock = ~write_port_clock;
    end
  end
  initial begin
    read_port_clock = 1'b0;
    forever begin
      repeat (5) @(posedge clock);
      #1 read_port_clock = ~read_port_clock;
    end
  end
  initial begin
    write_valid = 1'b0;
    write_data = 36'h0;
    read_ready = 1'b0;
  end

  // ****************************************************************
  // transfers: request held until the edge that sees ready
  // ****************************************************************
  task automatic put_word(input logic [frc_pkg::DATA_W-1:0] d, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clock);
    #1 write_valid = 1'b1;
    write_data = d;
    for (n = 0; n < 200 && !ok; n++) begin
      #1 ok = (full_or_input_ready_flag === 1'b1);
      @(posedge clock);
    end
    #1 write_valid = 1'b0;
    // a released bus must not keep showing the old word
    write_data = ~d;
  endtask

  task automatic get_half(output logic [frc_pkg::HALF_W-1:0] d, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge clock);
    #1 read_ready = 1'b1;
    for (n = 0; n < 200 && !ok; n++) begin
      #1 ok = (read_valid === 1'b1);
      d = read_data;
      @(posedge clock);
    end
    #1 read_ready = 1'b0;
  endtask
endmodule // frc_host

// >>> tb_fifo_reset_retransmit_control.sv
`timescale 1ns/100ps
module tb_fifo_reset_retransmit_control;
  logic clock, rstn, master_reset_first_n, master_reset_second_n, partial_reset_n;
  logic rewind_mode_select, byte_order_timing_select, offset_select_0, offset_select_1, offset_select_2;
  logic write_port_clock, read_port_clock, write_valid, read_valid, read_ready;
  logic [35:0] write_data;
  logic [17:0] read_data;
  logic mailbox_one_load, mailbox_one_take, mailbox_two_load, mailbox_two_take;
  logic full_or_input_ready_flag, empty_or_output_ready_flag, almost_empty_flag, almost_full_flag;
  logic mailbox_one_flag_n, mailbox_two_flag_n, byte_order_select, standard_timing_mode;
  logic [2:0] offset_method;
  int errors = 0;
  int num_checks = 0;
  int wr_rises = 0;
  localparam logic [35:0] WA = 36'h123456789;
  localparam logic [35:0] WB = 36'hABCDEF012;

  frc_top dut_u (.clock(clock), .rstn(rstn), .master_reset_first_n(master_reset_first_n),
    .master_reset_second_n(master_reset_second_n), .partial_reset_n(partial_reset_n),
    .rewind_mode_select(rewind_mode_select), .byte_order_timing_select(byte_order_timing_select),
    .offset_select_0(offset_select_0), .offset_select_1(offset_select_1), .offset_select_2(offset_select_2),
    .write_port_clock(write_port_clock), .read_port_clock(read_port_clock), .write_valid(write_valid),
    .write_data(write_data), .read_valid(read_valid), .read_ready(read_ready), .read_data(read_data),
    .mailbox_one_load(mailbox_one_load), .mailbox_one_take(mailbox_one_take),
    .mailbox_two_load(mailbox_two_load), .mailbox_two_take(mailbox_two_take),
    .full_or_input_ready_flag(full_or_input_ready_flag), .empty_or_output_ready_flag(empty_or_output_ready_flag),
    .almost_empty_flag(almost_empty_flag), .almost_full_flag(almost_full_flag),
    .mailbox_one_flag_n(mailbox_one_flag_n), .mailbox_two_flag_n(mailbox_two_flag_n),
    .byte_order_select(byte_order_select), .offset_method(offset_method),
    .standard_timing_mode(standard_timing_mode));

  frc_host host_u (.clock(clock), .write_port_clock(write_port_clock), .read_port_clock(read_port_clock),
    .write_valid(write_valid), .write_data(write_data), .full_or_input_ready_flag(full_or_input_ready_flag),
    .read_valid(read_valid), .read_ready(read_ready), .read_data(read_data));

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge write_port_clock) wr_rises++;

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic check_val(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic need(input bit ok);
    if (!ok) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // counts raw write clock rises until the write side reopens
  task automatic wake(output int rises);
    int n;
    int start;
    start = wr_rises;
    for (n = 0; n < 300 && full_or_input_ready_flag !== 1'b1; n++) step(1);
    need(n < 300);
    rises = wr_rises - start;
  endtask
  function automatic logic [17:0] half(input logic [35:0] w, input int i, input logic bo);
    return ((i == 0) == bo) ? w[35:18] : w[17:0];
  endfunction
  task automatic put(input logic [35:0] w);
    bit ok;
    host_u.put_word(w, ok);
    need(ok);
  endtask
  task automatic read_word(input logic [35:0] w, input logic bo, input int first);
    logic [17:0] d;
    bit ok;
    int i;
    for (i = first; i < 2; i++) begin
      host_u.get_half(d, ok);
      need(ok);
      check_val(36'(d), 36'(half(w, i, bo)));
    end
  endtask
  task automatic held_flags(input logic mb_one);
    check_flag(full_or_input_ready_flag, 1'b0);
    check_flag(empty_or_output_ready_flag, 1'b0);
    check_flag(almost_empty_flag, 1'b0);
    check_flag(almost_full_flag, 1'b1);
    check_flag(mailbox_one_flag_n, mb_one);
    check_flag(mailbox_two_flag_n, 1'b1);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic full_reset(input logic bto, input logic [2:0] fs);
    int r;
    master_reset_first_n = 1'b0;
    master_reset_second_n = 1'b0;
    byte_order_timing_select = bto;
    {offset_select_2, offset_select_1, offset_select_0} = fs;
    step(60);
    held_flags(1'b1);
    master_reset_first_n = 1'b1;
    master_reset_second_n = 1'b1;
    wake(r);
    check_flag(r >= 2 && r <= 3, 1'b1);
    step(12);
    check_val(36'(byte_order_select), 36'(bto));
    check_val(36'(offset_method), 36'(fs));
    check_flag(standard_timing_mode, bto);
  endtask

  task automatic stream(input logic bo);
    put(WA);
    put(WB);
    put(WA);
    put(WB);
    step(2);
    // one word in the output stage, three buffered: neither almost empty nor roomy
    check_flag(almost_empty_flag, 1'b1);
    check_flag(almost_full_flag, 1'b0);
    read_word(WA, bo, 0);
    read_word(WB, bo, 0);
    read_word(WA, bo, 0);
    read_word(WB, bo, 0);
  endtask

  // only the second master reset low: its mailbox alone is forced inactive
  task automatic second_reset_only();
    int r;
    mailbox_one_load = 1'b1;
    mailbox_two_load = 1'b1;
    step(1);
    mailbox_one_load = 1'b0;
    mailbox_two_load = 1'b0;
    step(3);
    check_flag(mailbox_two_flag_n, 1'b0);
    master_reset_second_n = 1'b0;
    step(60);
    check_flag(mailbox_two_flag_n, 1'b1);
    check_flag(mailbox_one_flag_n, 1'b0);
    master_reset_second_n = 1'b1;
    wake(r);
  endtask

  task automatic partial_reset();
    int r;
    put(WA);
    step(6);
    check_flag(empty_or_output_ready_flag, 1'b1);
    rewind_mode_select = 1'b0;
    // strap pins move during the partial reset; nothing may be recaptured
    byte_order_timing_select = 1'b0;
    {offset_select_2, offset_select_1, offset_select_0} = 3'h2;
    partial_reset_n = 1'b0;
    step(60);
    held_flags(1'b1);
    partial_reset_n = 1'b1;
    wake(r);
    check_flag(r >= 2 && r <= 3, 1'b1);
    step(12);
    check_flag(empty_or_output_ready_flag, 1'b0);
    check_val(36'(offset_method), 36'h5);
    check_flag(byte_order_select, 1'b1);
    check_flag(standard_timing_mode, 1'b1);
    byte_order_timing_select = 1'b1;
    {offset_select_2, offset_select_1, offset_select_0} = 3'h5;
  endtask

  task automatic rewind_read();
    logic [17:0] d;
    bit ok;
    put(WA);
    put(WB);
    read_word(WA, 1'b1, 0);
    rewind_mode_select = 1'b1;
    step(2);
    // a pulse shorter than four port clock edges must leave the read pointer alone
    partial_reset_n = 1'b0;
    step(1);
    partial_reset_n = 1'b1;
    step(6);
    read_word(WB, 1'b1, 0);
    partial_reset_n = 1'b0;
    step(60);
    partial_reset_n = 1'b1;
    step(8);
    rewind_mode_select = 1'b0;
    host_u.get_half(d, ok);
    need(ok);
    check_val(36'(d), 36'(WA[35:18]));
    read_word(WA, 1'b1, 1);
    read_word(WB, 1'b1, 0);
    check_flag(full_or_input_ready_flag, 1'b1);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rstn = 1'b0;
    master_reset_first_n = 1'b0;
    master_reset_second_n = 1'b0;
    partial_reset_n = 1'b1;
    rewind_mode_select = 1'b0;
    byte_order_timing_select = 1'b1;
    {offset_select_2, offset_select_1, offset_select_0} = 3'h5;
    {mailbox_one_load, mailbox_one_take, mailbox_two_load, mailbox_two_take} = 4'h0;
    step(4);
    rstn = 1'b1;
    full_reset(1'b1, 3'h5);
    stream(1'b1);
    second_reset_only();
    partial_reset();
    rewind_read();
    full_reset(1'b0, 3'h2);
    stream(1'b0);
    wrap_up();
  end
endmodule // tb_fifo_reset_retransmit_control
